//--- inc/dcc_pkg.sv
// shared constants and helpers for the debug comms channel
package dcc_pkg;

  // data path width of both mailboxes
  localparam int DATA_W = 32;

  // coprocessor number and register selects seen by the core
  localparam logic [3:0] CP_NUM_COMMS = 4'hE;
  localparam logic [3:0] CRN_CTRL     = 4'h0;
  localparam logic [3:0] CRN_DATA     = 4'h1;

  // handshake control word layout
  localparam int CTRL_R_BIT   = 0;
  localparam int CTRL_W_BIT   = 1;
  localparam int CTRL_VER_LSB = 28;
  localparam int CTRL_VER_W   = 4;

  // version pattern, value is arbitrary
  localparam logic [CTRL_VER_W-1:0] VERSION_ID = 4'h5;

  // scan frame layout: data, then address, then write flag
  localparam int SCAN_LEN     = 35;
  localparam int SCAN_ADDR_LSB = 32;
  localparam int SCAN_RW_BIT  = 34;
  localparam int SCAN_CNT_W   = 6;
  localparam logic [1:0] SCAN_ADDR_CTRL = 2'h0;
  localparam logic [1:0] SCAN_ADDR_DATA = 2'h1;

  // outbound buffer depth
  localparam int BUF_DEPTH = 2;

  // values after reset
  localparam logic R_FLAG_RST = 1'b0;
  localparam logic W_FLAG_RST = 1'b0;
  localparam logic INT_EN_RST = 1'b1;
  localparam logic LOW_PWR_RST = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 32'h00000000;

  // build the handshake control word from the two flags
  function automatic logic [DATA_W-1:0] ctrl_word(input logic w,
                                                   input logic r);
    logic [DATA_W-1:0] v;
    v = DATA_RST;
    v[CTRL_VER_LSB +: CTRL_VER_W] = VERSION_ID;
    v[CTRL_W_BIT] = w;
    v[CTRL_R_BIT] = r;
    return v;
  endfunction

endpackage

//--- core/dcc_buf.sv
// small valid/ready buffer for outbound words
`timescale 1ns/10ps
module dcc_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      cnt_ff;
  logic [AW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  // advance a pointer with wrap at the depth
  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    if (p == AW'(DEPTH - 1))
      return '0;
    else
      return p + AW'(1);
  endfunction

  // handshakes on both sides
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;
  assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  assign out_data_o = mem_ff[rd_ptr_ff];

  // storage written on push
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data_i;
  end

  // pointers, count and registered flags
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      wr_ptr_ff   <= '0;
      rd_ptr_ff   <= '0;
      cnt_ff      <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= step(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= step(rd_ptr_ff);
      cnt_ff      <= nxt_cnt;
      in_ready_o  <= nxt_cnt < (AW+1)'(DEPTH); // honest full
      out_valid_o <= nxt_cnt != '0;            // honest empty
    end
  end

endmodule

//--- core/dcc_top.sv
// debug comms channel with disable gating and condition sampling
// Contract
// - with debug disabled, breakpoint, halt request and ack low, irq on.
// - with debug disabled, the unit idles in a low-power mode.
// - external condition inputs are sampled on the core clock fall.
// - channel has 32-bit inbound, 32-bit outbound, 6-bit control.
// - control register is read-only, top nibble holds a version.
// - control bit 1 shows outbound register holds unread data.
// - control bit 0 shows inbound register holds uncollected data.
// - processor write to outbound data sets the write-full flag.
// - debugger read of outbound data pops one word; write-full clears once none remain.
// - debugger write of inbound data sets the read-full flag.
// - processor read of inbound data clears the read-full flag.
// - debugger sees both flags synchronised to the test clock.
// - processor sees read-full synchronised to the core clock.
// - core reaches channel as coprocessor 14, C0 control, C1 data.
`timescale 1ns/10ps
module dcc_top #(
  parameter int DATA_W    = dcc_pkg::DATA_W,
  parameter int BUF_DEPTH = dcc_pkg::BUF_DEPTH
) (
  input  wire logic              CLK_I,
  input  wire logic              SRST_I,
  input  wire logic              DEBUG_UNIT_ENABLE_I,
  input  wire logic              BKPT_IN_I,
  input  wire logic              HALT_REQ_IN_I,
  input  wire logic              HALT_ACK_IN_I,
  input  wire logic              INT_EN_IN_I,
  output logic                   BREAKPOINT_REQUEST_O,
  output logic                   HALT_REQUEST_O,
  output logic                   HALT_ACKNOWLEDGE_O,
  output logic                   CORE_INTERRUPT_ENABLE_O,
  output logic                   LOW_POWER_O,
  input  wire logic [1:0]        EXTERNAL_CONDITION_I,
  output logic      [1:0]        EXTERNAL_CONDITION_O,
  input  wire logic              COPROC_READ_TRANSFER_I,
  input  wire logic              COPROC_WRITE_TRANSFER_I,
  input  wire logic [3:0]        COPROC_NUM_I,
  input  wire logic [3:0]        COPROC_CRN_I,
  input  wire logic [DATA_W-1:0] COPROC_WDATA_I,
  output logic      [DATA_W-1:0] COPROC_RDATA_O,
  output logic                   COPROC_ACK_O,
  output logic                   COPROC_WR_READY_O,
  input  wire logic              SCAN_TCK_I,
  input  wire logic              SCAN_SEL_I,
  input  wire logic              SCAN_TDI_I,
  output logic                   SCAN_TDO_O
);

  localparam int SL = dcc_pkg::SCAN_LEN;
  localparam int CW = dcc_pkg::SCAN_CNT_W;

  // pin synchronisers
  logic [1:0]        en_sync_ff;
  logic [1:0]        tck_sync_ff;
  logic [1:0]        sel_sync_ff;
  logic [1:0]        tdi_sync_ff;
  logic              tck_d_ff;
  logic              sel_d_ff;
  logic              ext_neg_ff0;
  logic              ext_neg_ff1;

  // channel state
  logic [DATA_W-1:0] inbound_ff;
  logic              r_ff;
  logic              cp_r_ff;
  logic              dbg_w_ff;
  logic              dbg_r_ff;
  logic [SL-1:0]     shreg_ff;
  logic [CW-1:0]     bitcnt_ff;
  logic [SL-1:0]     nxt_load;

  // decode terms
  logic              debug_en;
  logic              tck_rise;
  logic              sel_fall;
  logic              frame_done;
  logic              cp_sel;
  logic              cp_rd_ctrl;
  logic              cp_rd_data;
  logic              cp_wr_data;
  logic              scan_wr;
  logic              scan_rd;
  logic [1:0]        scan_addr;
  logic              scan_wr_data;
  logic              scan_rd_data;
  logic              scan_rd_ctrl;

  // outbound buffer signals
  logic              buf_valid;
  logic [DATA_W-1:0] buf_data;

  // two-stage sampling of the enable and scan pin inputs
  // pins are asynchronous, only the second stage is read
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      en_sync_ff  <= 2'h0;
      tck_sync_ff <= 2'h0;
      sel_sync_ff <= 2'h0;
      tdi_sync_ff <= 2'h0;
    end
    else
    begin
      en_sync_ff  <= {en_sync_ff[0], DEBUG_UNIT_ENABLE_I};
      tck_sync_ff <= {tck_sync_ff[0], SCAN_TCK_I};
      sel_sync_ff <= {sel_sync_ff[0], SCAN_SEL_I};
      tdi_sync_ff <= {tdi_sync_ff[0], SCAN_TDI_I};
    end
  end

  // delayed copies for edge finding on the scan pins
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      tck_d_ff <= 1'b0;
      sel_d_ff <= 1'b0;
    end
    else
    begin
      tck_d_ff <= tck_sync_ff[1];
      sel_d_ff <= sel_sync_ff[1];
    end
  end

  assign debug_en = en_sync_ff[1];
  assign tck_rise = tck_sync_ff[1] & ~tck_d_ff;
  assign sel_fall = ~sel_sync_ff[1] & sel_d_ff;

  // condition inputs caught on the falling clock edge
  always_ff @(negedge CLK_I)
  begin
    if (SRST_I)
      ext_neg_ff0 <= 1'b0;
    else
      ext_neg_ff0 <= EXTERNAL_CONDITION_I[0];
  end

  always_ff @(negedge CLK_I)
  begin
    if (SRST_I)
      ext_neg_ff1 <= 1'b0;
    else
      ext_neg_ff1 <= EXTERNAL_CONDITION_I[1];
  end

  // second stage back on the rising edge
  // with the falling-edge flop this forms the pin synchroniser
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      EXTERNAL_CONDITION_O <= 2'h0;
    else
      EXTERNAL_CONDITION_O <= {ext_neg_ff1, ext_neg_ff0};
  end

  // core-facing debug lines, forced when the unit is disabled
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      BREAKPOINT_REQUEST_O    <= 1'b0;
      HALT_REQUEST_O          <= 1'b0;
      HALT_ACKNOWLEDGE_O      <= 1'b0;
      CORE_INTERRUPT_ENABLE_O <= dcc_pkg::INT_EN_RST;
    end
    else
    begin
      BREAKPOINT_REQUEST_O    <= debug_en & BKPT_IN_I;
      HALT_REQUEST_O          <= debug_en & HALT_REQ_IN_I;
      HALT_ACKNOWLEDGE_O      <= debug_en & HALT_ACK_IN_I;
      CORE_INTERRUPT_ENABLE_O <= ~debug_en | INT_EN_IN_I;
    end
  end

  // low-power indication is the inverse of the enable
  // the gated outputs above stay still while this is high
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      LOW_POWER_O <= dcc_pkg::LOW_PWR_RST;
    else
      LOW_POWER_O <= ~debug_en;
  end

  // one strobe aimed at one coprocessor register
  function automatic logic cp_match(input logic       strobe,
                                    input logic [3:0] crn,
                                    input logic [3:0] want);
    return strobe & (crn == want);
  endfunction

  // coprocessor transfer decode, nothing taken while disabled
  assign cp_sel = debug_en & (COPROC_NUM_I == dcc_pkg::CP_NUM_COMMS);
  assign cp_rd_ctrl = cp_sel & cp_match(COPROC_READ_TRANSFER_I,
                      COPROC_CRN_I, dcc_pkg::CRN_CTRL);
  assign cp_rd_data = cp_sel & cp_match(COPROC_READ_TRANSFER_I,
                      COPROC_CRN_I, dcc_pkg::CRN_DATA);
  assign cp_wr_data = cp_sel & cp_match(COPROC_WRITE_TRANSFER_I,
                      COPROC_CRN_I, dcc_pkg::CRN_DATA);

  // scan frame decode at the end of a full-length frame
  assign frame_done = debug_en & sel_fall
                      & (bitcnt_ff == CW'(SL));
  assign scan_wr    = frame_done & shreg_ff[dcc_pkg::SCAN_RW_BIT];
  assign scan_rd    = frame_done & ~shreg_ff[dcc_pkg::SCAN_RW_BIT];
  assign scan_addr  = shreg_ff[dcc_pkg::SCAN_ADDR_LSB +: 2];
  // a deposit into a still-full inbound register is dropped
  assign scan_wr_data = scan_wr & (scan_addr == dcc_pkg::SCAN_ADDR_DATA)
                        & ~r_ff;
  assign scan_rd_data = scan_rd & (scan_addr == dcc_pkg::SCAN_ADDR_DATA);
  assign scan_rd_ctrl = scan_rd & (scan_addr == dcc_pkg::SCAN_ADDR_CTRL);

  // outbound path: write-full is the buffer holding any word
  // a write while full is still answered, but its word is dropped
  dcc_buf #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_outbound (
    .clk_i       (CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (cp_wr_data),
    .in_data_i   (COPROC_WDATA_I),
    .in_ready_o  (COPROC_WR_READY_O),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (scan_rd_data)
  );

  // inbound data register filled from the scan chain
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      inbound_ff <= dcc_pkg::DATA_RST;
    else if (scan_wr_data)
      inbound_ff <= shreg_ff[DATA_W-1:0];
  end

  // read-full flag, a deposit wins over a same-cycle collect
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      r_ff <= dcc_pkg::R_FLAG_RST;
    else if (scan_wr_data)
      r_ff <= 1'b1;
    else if (cp_rd_data)
      r_ff <= 1'b0;
  end

  // core-clock copy of read-full for the processor
  // one stage suffices, the flag already lives on the core clock
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      cp_r_ff <= dcc_pkg::R_FLAG_RST;
    else
      cp_r_ff <= r_ff;
  end

  // test-clock copies of both flags for the debugger
  // taken only at a test clock rise, so they change with each shift and hold between rises
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      dbg_w_ff <= dcc_pkg::W_FLAG_RST;
      dbg_r_ff <= dcc_pkg::R_FLAG_RST;
    end
    else if (tck_rise)
    begin
      dbg_w_ff <= buf_valid;
      dbg_r_ff <= r_ff;
    end
  end

  // word loaded into the chain for shifting out in the next frame
  always_comb
  begin
    nxt_load = '0;
    if (scan_rd_ctrl)
      nxt_load[DATA_W-1:0] = dcc_pkg::ctrl_word(dbg_w_ff, dbg_r_ff);
    else if (scan_rd_data && buf_valid)
      nxt_load[DATA_W-1:0] = buf_data;
  end

  // scan shift register, frozen while the unit is disabled
  // bit 0 of a loaded word waits on the output before the first rise
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      shreg_ff   <= '0;
      bitcnt_ff  <= '0;
      SCAN_TDO_O <= 1'b0;
    end
    else if (debug_en)
    begin
      if (frame_done)
      begin
        shreg_ff   <= nxt_load;
        SCAN_TDO_O <= nxt_load[0];
        bitcnt_ff  <= '0;
      end
      else if (sel_fall)
        bitcnt_ff <= '0; // short or long frame discarded
      else if (tck_rise && sel_sync_ff[1])
      begin
        shreg_ff   <= {tdi_sync_ff[1], shreg_ff[SL-1:1]};
        SCAN_TDO_O <= shreg_ff[1];
        if (bitcnt_ff != '1)
          bitcnt_ff <= bitcnt_ff + CW'(1);
      end
    end
  end

  // processor read data and acknowledge
  // data reads as zero outside the answer cycle
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      COPROC_RDATA_O <= dcc_pkg::DATA_RST;
      COPROC_ACK_O   <= 1'b0;
    end
    else
    begin
      COPROC_ACK_O <= cp_rd_ctrl | cp_rd_data | cp_wr_data;
      if (cp_rd_ctrl)
        COPROC_RDATA_O <= dcc_pkg::ctrl_word(buf_valid, cp_r_ff);
      else if (cp_rd_data)
        COPROC_RDATA_O <= inbound_ff;
      else
        COPROC_RDATA_O <= dcc_pkg::DATA_RST;
    end
  end

endmodule

//--- sim/dcc_top_properties.sv
// port-level assertions for the debug comms channel
`timescale 1ns/10ps
module dcc_top_properties #(
  parameter int DATA_W    = dcc_pkg::DATA_W,
  parameter int BUF_DEPTH = dcc_pkg::BUF_DEPTH
) (
  input wire logic              CLK_I,
  input wire logic              SRST_I,
  input wire logic              DEBUG_UNIT_ENABLE_I,
  input wire logic              BKPT_IN_I,
  input wire logic              HALT_REQ_IN_I,
  input wire logic              HALT_ACK_IN_I,
  input wire logic              INT_EN_IN_I,
  input wire logic              BREAKPOINT_REQUEST_O,
  input wire logic              HALT_REQUEST_O,
  input wire logic              HALT_ACKNOWLEDGE_O,
  input wire logic              CORE_INTERRUPT_ENABLE_O,
  input wire logic              LOW_POWER_O,
  input wire logic [1:0]        EXTERNAL_CONDITION_I,
  input wire logic [1:0]        EXTERNAL_CONDITION_O,
  input wire logic              COPROC_READ_TRANSFER_I,
  input wire logic              COPROC_WRITE_TRANSFER_I,
  input wire logic [3:0]        COPROC_NUM_I,
  input wire logic [3:0]        COPROC_CRN_I,
  input wire logic [DATA_W-1:0] COPROC_WDATA_I,
  input wire logic [DATA_W-1:0] COPROC_RDATA_O,
  input wire logic              COPROC_ACK_O,
  input wire logic              COPROC_WR_READY_O,
  input wire logic              SCAN_TCK_I,
  input wire logic              SCAN_SEL_I,
  input wire logic              SCAN_TDI_I,
  input wire logic              SCAN_TDO_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  logic hit, req, on, rd_ctl, wr_dat;
  // decoded channel requests and settled enable
  assign hit = COPROC_NUM_I == dcc_pkg::CP_NUM_COMMS;
  assign req = hit && (COPROC_READ_TRANSFER_I || COPROC_WRITE_TRANSFER_I);
  assign rd_ctl = hit && COPROC_READ_TRANSFER_I && COPROC_CRN_I == 4'h0;
  assign wr_dat = hit && COPROC_WRITE_TRANSFER_I && COPROC_CRN_I == 4'h1;
  assign on = DEBUG_UNIT_ENABLE_I && !SRST_I;

  dis_gate_a: assert property (!DEBUG_UNIT_ENABLE_I [*4] |->
    !BREAKPOINT_REQUEST_O && !HALT_REQUEST_O && !HALT_ACKNOWLEDGE_O &&
    CORE_INTERRUPT_ENABLE_O && LOW_POWER_O) else $error("not gated");
  en_pass_a: assert property (on [*4] |-> !LOW_POWER_O &&
    BREAKPOINT_REQUEST_O == $past(BKPT_IN_I) &&
    CORE_INTERRUPT_ENABLE_O == $past(INT_EN_IN_I)) else $error("no pass");
  ext_cond_a: assert property (on [*4] |->
    EXTERNAL_CONDITION_O == $past(EXTERNAL_CONDITION_I))
    else $error("condition sampled late");
  ack_src_a: assert property (COPROC_ACK_O |-> $past(req))
    else $error("answer without request");
  ctl_rd_a: assert property (on [*3] ##0 rd_ctl |=> COPROC_ACK_O &&
    COPROC_RDATA_O[31:28] == dcc_pkg::VERSION_ID &&
    COPROC_RDATA_O[27:2] == 26'h0) else $error("bad control read");
  wr_ctl_a: assert property (hit && COPROC_WRITE_TRANSFER_I &&
    !COPROC_READ_TRANSFER_I && COPROC_CRN_I == 4'h0 |=> !COPROC_ACK_O)
    else $error("control register took a write");
  w_set_a: assert property (wr_dat ##1 (rd_ctl && COPROC_ACK_O) |=>
    COPROC_RDATA_O[1]) else $error("write-full not set");
  tdo_idle_a: assert property ((!SCAN_SEL_I && !SCAN_TCK_I) [*8] |->
    $stable(SCAN_TDO_O)) else $error("scan output moved while idle");

  cover property (wr_dat ##1 COPROC_ACK_O);
  cover property (rd_ctl ##1 COPROC_ACK_O);
  cover property ($fell(SCAN_SEL_I));
endmodule
bind dcc_top dcc_top_properties #(.DATA_W(DATA_W), .BUF_DEPTH(BUF_DEPTH))
  chk_u (.*);

//--- sim/dcc_host.sv
// scan-chain host model that shifts frames into the channel
`timescale 1ns/10ps
module dcc_host (
  input  wire logic clk_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      sel_o,
  output logic      tdi_o
);
  // link clock stands still low outside frames
  initial
  begin
    {tck_o, sel_o, tdi_o} = 3'h0;
  end
  // one frame lsb first; q gets the word loaded by the previous frame
  task automatic frame(input logic [34:0] f, output logic [31:0] q);
    q = 32'h0;
    // only comms registers are ever addressed, never the watchpoints
    @(posedge clk_i) sel_o <= 1'b1;
    for (int i = 0; i < 35; i++)
    begin
      // new bit with the falling link clock, 8 core cycles a period
      tdi_o <= f[i];
      repeat (4) @(posedge clk_i);
      if (i < 32) q[i] = tdo_i;
      tck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      tck_o <= 1'b0;
    end
    // released data line shows the inverse of its last bit
    @(posedge clk_i) sel_o <= 1'b0;
    tdi_o <= ~tdi_o;
    repeat (8) @(posedge clk_i);
  endtask
endmodule

//--- sim/dcc_top_tb.sv
// self-checking bench for the debug comms channel
`timescale 1ns/10ps
module dcc_top_tb;
  logic        clk = 1'b0, rst = 1'b1, en = 1'b0, bk = 1'b0, hq = 1'b0;
  logic        ha = 1'b0, ie = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [1:0]  xi = 2'h0;
  logic [3:0]  num = 4'h0, crn = 4'h0;
  logic [31:0] wd = 32'h0;
  logic        ob, oq, oa, oi, lp, ack, wrdy, tck, sel, tdi, tdo;
  logic [1:0]  xo;
  logic [31:0] rq;
  int          err_count = 0;
  int          n_tests = 0;

  dcc_top dut_u (
    .CLK_I(clk), .SRST_I(rst), .DEBUG_UNIT_ENABLE_I(en), .BKPT_IN_I(bk),
    .HALT_REQ_IN_I(hq), .HALT_ACK_IN_I(ha), .INT_EN_IN_I(ie),
    .BREAKPOINT_REQUEST_O(ob), .HALT_REQUEST_O(oq),
    .HALT_ACKNOWLEDGE_O(oa), .CORE_INTERRUPT_ENABLE_O(oi),
    .LOW_POWER_O(lp), .EXTERNAL_CONDITION_I(xi), .EXTERNAL_CONDITION_O(xo),
    .COPROC_READ_TRANSFER_I(rd), .COPROC_WRITE_TRANSFER_I(wr),
    .COPROC_NUM_I(num), .COPROC_CRN_I(crn), .COPROC_WDATA_I(wd),
    .COPROC_RDATA_O(rq), .COPROC_ACK_O(ack), .COPROC_WR_READY_O(wrdy),
    .SCAN_TCK_I(tck), .SCAN_SEL_I(sel), .SCAN_TDI_I(tdi), .SCAN_TDO_O(tdo)
  );
  dcc_host host_u (.clk_i(clk), .tdo_i(tdo), .tck_o(tck), .sel_o(sel),
    .tdi_o(tdi));

  // 20 MHz core clock
  initial
  begin
    forever #25 clk = ~clk;
  end

  // expected control word from the two flags
  function automatic logic [31:0] exp_ctrl(input logic w, input logic r);
    return {dcc_pkg::VERSION_ID, 26'h0, w, r};
  endfunction

  // compare, count and report
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %0h, expected %0h", $time, got, exp);
    end
  endtask

  // one coprocessor transfer; q holds the answer flag and read data
  task automatic cp(input logic r, input logic [3:0] n, input logic [3:0] c,
                    input logic [31:0] d, output logic [32:0] q);
    @(posedge clk) {rd, wr, num, crn, wd} <= {r, !r, n, c, d};
    @(posedge clk) {rd, wr} <= 2'h0;
    #1 q = {ack, rq};
  endtask

  task automatic give_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard
  initial
  begin
    #2000000;
    err_count++;
    give_verdict;
  end

  // main sequence
  initial
  begin
    logic [32:0] q;
    logic [31:0] h, w0, w1;
    h = $urandom(16);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1 chk({oi, lp, wrdy, ack}, 4'hE);
    cp(1'b1, 4'hE, 4'h0, 32'h0, q);
    chk(q[32], 1'b0);
    // random debug levels, first disabled then enabled
    for (int i = 0; i < 14; i++)
    begin
      h = $urandom;
      @(posedge clk) {en, bk, hq, ha, ie, xi} <= {i > 5, h[5:0]};
      @(posedge clk) #1;
      if (i < 6) chk({ob, oq, oa, oi, lp}, 5'h3);
      else if (i > 7) chk({lp, ob, oq, oa, oi, xo}, {1'b0, h[5:0]});
    end
    cp(1'b1, 4'hE, 4'h0, 32'h0, q);
    chk(q, {1'b1, exp_ctrl(1'b0, 1'b0)});
    cp(1'b1, h[3:0] % 4'hE, 4'h1, 32'h0, q);
    chk(q[32], 1'b0);
    cp(1'b0, 4'hE, 4'h0, h, q);
    chk(q[32], 1'b0);
    // two words out with one idle cycle between, a control read, then one dropped
    w0 = $urandom;
    w1 = $urandom;
    cp(1'b0, 4'hE, 4'h1, w0, q);
    chk(q[32], 1'b1);
    @(posedge clk) {wr, crn, wd} <= {1'b1, 4'h1, w1};
    @(posedge clk) {wr, rd, crn} <= {1'b0, 1'b1, 4'h0};
    @(posedge clk) rd <= 1'b0;
    #1 chk({ack, rq}, {1'b1, exp_ctrl(1'b1, 1'b0)});
    chk(wrdy, 1'b0);
    cp(1'b0, 4'hE, 4'h1, h, q);
    chk(q[32], 1'b1);
    host_u.frame(35'h0, h);
    host_u.frame(35'h100000000, h);
    chk(h, exp_ctrl(1'b1, 1'b0));
    host_u.frame(35'h100000000, h);
    chk(h, w0);
    host_u.frame(35'h0, h);
    chk(h, w1);
    host_u.frame(35'h0, h);
    chk(h, exp_ctrl(1'b0, 1'b0));
    cp(1'b1, 4'hE, 4'h0, 32'h0, q);
    chk(q, {1'b1, exp_ctrl(1'b0, 1'b0)});
    // words in from the host, one refused while the slot is full
    for (int i = 0; i < 2; i++)
    begin
      w0 = $urandom;
      w1 = $urandom;
      host_u.frame(35'h0, h);
      host_u.frame({3'h5, w0}, h);
      chk(h[0], 1'b0);
      repeat (6) @(posedge clk);
      cp(1'b1, 4'hE, 4'h0, 32'h0, q);
      chk(q, {1'b1, exp_ctrl(1'b0, 1'b1)});
      host_u.frame({3'h5, w1}, h);
      cp(1'b1, 4'hE, 4'h1, 32'h0, q);
      chk(q, {1'b1, w0});
      repeat (3) @(posedge clk);
      cp(1'b1, 4'hE, 4'h0, 32'h0, q);
      chk(q, {1'b1, exp_ctrl(1'b0, 1'b0)});
    end
    give_verdict;
  end
endmodule
